/* File: core/elic_pkg.sv */
package elic_pkg;

  // ----------------------------------------------------------------
  // register selection and command word fields
  // ----------------------------------------------------------------
  localparam logic OFS_COMMAND   = 1'b0;
  localparam logic OFS_DATA_PORT = 1'b1;

  localparam int W1_NEED_FOURTH = 0;
  localparam int W1_SINGLE      = 1;
  localparam int W1_INTERVAL4   = 2;
  localparam int W1_LEVEL_TRIG  = 3;
  localparam int W1_SELECT      = 4;
  localparam int W1_BASE_LO     = 5;
  localparam int W2_DONE        = 5;
  localparam int W2_SPECIFIC    = 6;
  localparam int W3_SELECT      = 3;
  localparam int W3_READ_SVC    = 0;
  localparam int W3_READ_REQ    = 1;
  localparam int W3_POLL        = 2;
  localparam int W4_HOST16      = 0;
  localparam int W4_AUTO_CLEAR  = 1;
  localparam int W4_MASTER      = 2;
  localparam int W4_BUFFERED    = 3;

  // ----------------------------------------------------------------
  // acknowledge sequence and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CALL_OPCODE    = 8'hcd;
  localparam logic [2:0] IDLE_LEVEL     = 3'h7;
  localparam logic [1:0] ACK_FIRST      = 2'h1;
  localparam logic [1:0] ACK_SECOND     = 2'h2;
  localparam logic [1:0] ACK_LAST_HOST8 = 2'h3;
  localparam logic [1:0] ACK_LAST_HOST16 = 2'h2;
  localparam logic [7:0] MASK_RST       = 8'h00;
  localparam logic [7:0] BITS_RST       = 8'h00;

  typedef enum logic [1:0] {
    INIT_READY,
    INIT_WAIT2,
    INIT_WAIT3,
    INIT_WAIT4
  } elic_init_t;

  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic       regSel;
    logic [7:0] data;
    logic       ackN;
    logic       spIn;
    logic [2:0] casIn;
    logic [7:0] req;
  } elic_pins_t;

  typedef struct packed {
    logic [2:0] lowBase;
    logic       levelTrig;
    logic       interval4;
    logic       single;
    logic       needFourth;
    logic [7:0] vecHigh;
    logic [7:0] cascMask;
    logic       host16;
    logic       autoClear;
    logic       bufMaster;
    logic       buffered;
  } elic_cfg_t;

  localparam elic_pins_t PINS_RST = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1,
    regSel: 1'b0, data: 8'h00, ackN: 1'b1, spIn: 1'b1, casIn: 3'h0,
    req: 8'h00};
  localparam elic_cfg_t CFG_RST = '0;

  // index of the highest priority (lowest numbered) set bit
  function automatic logic [2:0] lowestSet(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction

endpackage

/* File: core/elic_sync.sv */
`timescale 1ns/1ps
module elic_sync
  import elic_pkg::*;
(
  input  wire logic       sys_clk,  // system clock
  input  wire logic       resetn,   // async reset, active low
  input  wire elic_pins_t asyncIn,  // raw pin levels
  output elic_pins_t      syncOut   // pin levels after two flops
);
  elic_pins_t metaQ_q;
  elic_pins_t metaQ_d;
  elic_pins_t sync_q;
  elic_pins_t sync_d;

  always_comb
  begin
    metaQ_d = asyncIn;
    sync_d  = metaQ_q;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      metaQ_q <= PINS_RST;
      sync_q  <= PINS_RST;
    end
    else
    begin
      metaQ_q <= metaQ_d;
      sync_q  <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule

/* File: core/elic_prio.sv */
`timescale 1ns/1ps
module elic_prio
  import elic_pkg::*;
(
  input  wire logic [7:0] pending,    // unmasked requests
  input  wire logic [7:0] inService,  // levels being serviced
  output logic            found,      // a request may interrupt
  output logic [2:0]      level       // winning level
);
  // fully nested: level 0 highest, equal or lower levels wait
  always_comb
  begin
    level = lowestSet(pending);
    found = (|pending) &&
            (inService == BITS_RST || level < lowestSet(inService));
  end
endmodule

/* File: core/elic_core.sv */
`timescale 1ns/1ps
module elic_core
  import elic_pkg::*;
(
  input  wire logic       sys_clk,           // 40 MHz clock
  input  wire logic       resetn,            // async reset, active low
  input  wire logic       csN,               // chip select
  input  wire logic       rdN,               // read strobe
  input  wire logic       wrN,               // write strobe
  input  wire logic       regSel,            // register select bit
  input  wire logic [7:0] dataIn,            // data bus in
  output logic      [7:0] dataOut,           // data bus out
  output logic            dataOe,            // data bus drive enable
  input  wire logic       irqAckN,           // acknowledge pulse
  input  wire logic [7:0] requestIn,         // request inputs
  output logic            intOut,            // interrupt to host
  input  wire logic [2:0] cascadeSelIn,      // cascade lines in
  output logic      [2:0] cascadeSelOut,     // cascade lines out
  output logic            cascadeSelOe,      // cascade drive enable
  input  wire logic       slaveProgBufEnIn,  // slave program in
  output logic            slaveProgBufEnOut, // buffer enable out
  output logic            slaveProgBufEnOe   // buffer enable drive
);
  elic_pins_t pinsRaw;
  elic_pins_t pin;
  elic_pins_t prv_q;
  elic_init_t initState_q;
  elic_init_t initState_d;
  elic_cfg_t  cfg_q;
  elic_cfg_t  cfg_d;
  logic [7:0] imr_q;
  logic [7:0] imr_d;
  logic [7:0] irr_q;
  logic [7:0] irr_d;
  logic [7:0] isr_q;
  logic [7:0] isr_d;
  logic       readIsr_q;
  logic       readIsr_d;
  logic       poll_q;
  logic       poll_d;
  logic [1:0] ackCnt_q;
  logic [1:0] ackCnt_d;
  logic [2:0] ackLevel_q;
  logic [2:0] ackLevel_d;
  logic       ackNoSvc_q;
  logic       ackNoSvc_d;
  logic       ackCasc_q;
  logic       ackCasc_d;
  logic [7:0] dataOut_q;
  logic [7:0] dataOut_d;
  logic       dataOe_q;
  logic       dataOe_d;
  logic [2:0] casOut_q;
  logic [2:0] casOut_d;
  logic       int_q;
  logic       int_d;
  logic [7:0] isrSet;
  logic [7:0] isrClr;
  logic [7:0] irrSet;
  logic [7:0] irrClr;
  logic [7:0] ackByte;
  logic [7:0] readByte;
  logic [7:0] lowVec;
  logic [1:0] lastCount;
  logic       ours;
  logic       ackDrive;
  logic       found;
  logic [2:0] level;
  logic       isMaster;
  logic       casMatch;
  logic       wrStart;
  logic       rdEnd;
  logic       ackStart;
  logic       ackEnd;

  // ----------------------------------------------------------------
  // pin synchronisation and strobe edges
  // ----------------------------------------------------------------
  assign pinsRaw = '{csN: csN, rdN: rdN, wrN: wrN, regSel: regSel,
    data: dataIn, ackN: irqAckN, spIn: slaveProgBufEnIn,
    casIn: cascadeSelIn, req: requestIn};

  elic_sync uSync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .asyncIn (pinsRaw),
    .syncOut (pin)
  );

  assign wrStart  = prv_q.wrN && !pin.wrN && !pin.csN && pin.rdN;
  assign rdEnd    = !prv_q.rdN && pin.rdN && !prv_q.csN;
  assign ackStart = prv_q.ackN && !pin.ackN;
  assign ackEnd   = !prv_q.ackN && pin.ackN;

  // ----------------------------------------------------------------
  // priority and cascade role
  // ----------------------------------------------------------------
  elic_prio uPrio (
    .pending   (irr_q & ~imr_q),
    .inService (isr_q),
    .found     (found),
    .level     (level)
  );

  assign isMaster  = cfg_q.buffered ? cfg_q.bufMaster : pin.spIn;
  assign casMatch  = pin.casIn == cfg_q.cascMask[2:0];
  assign lastCount = cfg_q.host16 ? ACK_LAST_HOST16 : ACK_LAST_HOST8;
  assign irrSet    = cfg_q.levelTrig ? pin.req :
                     pin.req & ~prv_q.req;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    initState_d = initState_q;
    cfg_d       = cfg_q;
    imr_d       = imr_q;
    readIsr_d   = readIsr_q;
    poll_d      = poll_q;
    ackCnt_d    = ackCnt_q;
    ackLevel_d  = ackLevel_q;
    ackNoSvc_d  = ackNoSvc_q;
    ackCasc_d   = ackCasc_q;
    isrSet      = BITS_RST;
    isrClr      = BITS_RST;
    irrClr      = BITS_RST;
    // command writes
    if (wrStart && pin.regSel == OFS_COMMAND && pin.data[W1_SELECT])
    begin
      cfg_d.lowBase    = pin.data[7:W1_BASE_LO];
      cfg_d.levelTrig  = pin.data[W1_LEVEL_TRIG];
      cfg_d.interval4  = pin.data[W1_INTERVAL4];
      cfg_d.single     = pin.data[W1_SINGLE];
      cfg_d.needFourth = pin.data[W1_NEED_FOURTH];
      cfg_d.host16     = 1'b0;
      cfg_d.autoClear  = 1'b0;
      cfg_d.buffered   = 1'b0;
      cfg_d.bufMaster  = 1'b0;
      imr_d            = MASK_RST;
      isrClr           = 8'hff;
      readIsr_d        = 1'b0;
      poll_d           = 1'b0;
      initState_d      = INIT_WAIT2;
    end
    else if (wrStart && pin.regSel == OFS_COMMAND)
    begin
      if (!pin.data[W3_SELECT])
      begin
        if (pin.data[W2_DONE] && pin.data[W2_SPECIFIC])
          isrClr = 8'h01 << pin.data[2:0];
        else if (pin.data[W2_DONE])
          isrClr = (8'h01 << lowestSet(isr_q)) & isr_q;
      end
      else
      begin
        if (pin.data[W3_READ_REQ])
          readIsr_d = pin.data[W3_READ_SVC];
        poll_d = pin.data[W3_POLL];
      end
    end
    else if (wrStart)
    begin
      unique case (initState_q)
        INIT_READY:
          imr_d = pin.data;
        INIT_WAIT2:
        begin
          cfg_d.vecHigh = pin.data;
          if (!cfg_q.single)
            initState_d = INIT_WAIT3;
          else
            initState_d = cfg_q.needFourth ? INIT_WAIT4 : INIT_READY;
        end
        INIT_WAIT3:
        begin
          cfg_d.cascMask = pin.data;
          initState_d = cfg_q.needFourth ? INIT_WAIT4 : INIT_READY;
        end
        INIT_WAIT4:
        begin
          cfg_d.host16    = pin.data[W4_HOST16];
          cfg_d.autoClear = pin.data[W4_AUTO_CLEAR];
          cfg_d.bufMaster = pin.data[W4_MASTER];
          cfg_d.buffered  = pin.data[W4_BUFFERED];
          initState_d     = INIT_READY;
        end
      endcase
    end
    // acknowledge sequence
    if (ackStart)
    begin
      ackCnt_d = ackCnt_q + 2'h1;
      if (ackCnt_q == 2'h0)
      begin
        ackLevel_d = found ? level : IDLE_LEVEL;
        ackNoSvc_d = !found;
        ackCasc_d  = found && isMaster && !cfg_q.single &&
                     cfg_q.cascMask[level];
      end
    end
    ours = isMaster ? !ackCasc_d : casMatch;
    if (ackStart && ackCnt_d == lastCount && ours && !ackNoSvc_d)
    begin
      isrSet = 8'h01 << ackLevel_d;
      irrClr = 8'h01 << ackLevel_d;
    end
    if (ackEnd && ackCnt_q == lastCount)
    begin
      ackCnt_d = 2'h0;
      if (cfg_q.autoClear && ours && !ackNoSvc_q)
        isrClr = isrClr | (8'h01 << ackLevel_q);
    end
    // poll read takes the winning level into service
    if (rdEnd && poll_q)
    begin
      poll_d = 1'b0;
      if (found)
      begin
        isrSet = isrSet | (8'h01 << level);
        irrClr = irrClr | (8'h01 << level);
      end
    end
    isr_d = (isr_q & ~isrClr) | isrSet;
    irr_d = ((irr_q & ~irrClr) | irrSet) & pin.req;
    // bus output
    lowVec = cfg_q.interval4 ? {cfg_q.lowBase, ackLevel_d, 2'h0} :
             {cfg_q.lowBase[2:1], ackLevel_d, 3'h0};
    ackByte  = cfg_q.vecHigh;
    ackDrive = 1'b0;
    if (!pin.ackN && ackCnt_d == ACK_FIRST)
    begin
      ackByte  = CALL_OPCODE;
      ackDrive = !cfg_q.host16 && isMaster;
    end
    else if (!pin.ackN && ackCnt_d == ACK_SECOND)
    begin
      ackByte  = cfg_q.host16 ? {cfg_q.vecHigh[7:3], ackLevel_d} :
                 lowVec;
      ackDrive = ours;
    end
    else if (!pin.ackN && ackCnt_d == ACK_LAST_HOST8)
      ackDrive = ours;
    if (pin.regSel == OFS_DATA_PORT)
      readByte = imr_q;
    else if (poll_q)
      readByte = {found, 4'h0, level};
    else
      readByte = readIsr_q ? isr_q : irr_q;
    dataOe_d  = ackDrive || (!pin.csN && !pin.rdN && pin.wrN);
    dataOut_d = ackDrive ? ackByte : readByte;
    casOut_d  = (ackCnt_d != 2'h0 && ackCasc_d) ? ackLevel_d : 3'h0;
    int_d     = found && ackCnt_q == 2'h0 &&
                initState_q == INIT_READY;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prv_q       <= PINS_RST;
      initState_q <= INIT_READY;
      cfg_q       <= CFG_RST;
      imr_q       <= MASK_RST;
      irr_q       <= BITS_RST;
      isr_q       <= BITS_RST;
      readIsr_q   <= 1'b0;
      poll_q      <= 1'b0;
      ackCnt_q    <= 2'h0;
      ackLevel_q  <= IDLE_LEVEL;
      ackNoSvc_q  <= 1'b0;
      ackCasc_q   <= 1'b0;
      dataOut_q   <= BITS_RST;
      dataOe_q    <= 1'b0;
      casOut_q    <= 3'h0;
      int_q       <= 1'b0;
    end
    else
    begin
      prv_q       <= pin;
      initState_q <= initState_d;
      cfg_q       <= cfg_d;
      imr_q       <= imr_d;
      irr_q       <= irr_d;
      isr_q       <= isr_d;
      readIsr_q   <= readIsr_d;
      poll_q      <= poll_d;
      ackCnt_q    <= ackCnt_d;
      ackLevel_q  <= ackLevel_d;
      ackNoSvc_q  <= ackNoSvc_d;
      ackCasc_q   <= ackCasc_d;
      dataOut_q   <= dataOut_d;
      dataOe_q    <= dataOe_d;
      casOut_q    <= casOut_d;
      int_q       <= int_d;
    end
  end

  assign dataOut           = dataOut_q;
  assign dataOe            = dataOe_q;
  assign intOut            = int_q;
  assign cascadeSelOut     = casOut_q;
  assign cascadeSelOe      = isMaster && !cfg_q.single;
  assign slaveProgBufEnOut = !dataOe_q;
  assign slaveProgBufEnOe  = cfg_q.buffered;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence lastAckEnd;
    ackEnd && ackCnt_q == lastCount && cfg_q.autoClear && ours &&
    !ackNoSvc_q;
  endsequence

  sequence levelRiseHeld;
    cfg_q.levelTrig && $rose(requestIn[5]) ##1 requestIn[5] [*2];
  endsequence

  read_gate_a: assert property ($rose(dataOe_q) |->
    $past(!pin.csN && !pin.rdN) || $past(!pin.ackN))
    else $error("bus driven without read or acknowledge");
  int_raise_a: assert property (
    (|(irr_q & ~imr_q)) && isr_q == BITS_RST && ackCnt_q == 2'h0 &&
    initState_q == INIT_READY |=> intOut)
    else $error("interrupt output not raised");
  req_sync_a: assert property (levelRiseHeld |=> irr_q[5])
    else $error("level request not captured after two flops");
  call_byte_a: assert property (
    dataOe_q && $past(!pin.ackN) && $past(ackCnt_d) == ACK_FIRST |->
    dataOut_q == CALL_OPCODE)
    else $error("first acknowledge byte is not the call opcode");
  float_first_a: assert property (
    cfg_q.host16 && !pin.ackN && ackCnt_d == ACK_FIRST && pin.csN |=>
    !dataOe_q)
    else $error("bus driven on first acknowledge of wide host");
  buf_enable_a: assert property (
    cfg_q.buffered && $rose(dataOe_q) |-> $fell(slaveProgBufEnOut))
    else $error("buffer enable not low with bus drive");
  auto_clear_a: assert property (lastAckEnd |=>
    isr_q[$past(ackLevel_q)] == 1'b0)
    else $error("service bit not cleared at last acknowledge");
  no_service_a: assert property (
    ackStart && ackCnt_q == 2'h0 && !found |=>
    ackNoSvc_q && ackLevel_q == IDLE_LEVEL && isr_q == $past(isr_q))
    else $error("dropped request not mapped to level seven");
  mask_write_a: assert property (
    wrStart && pin.regSel == OFS_DATA_PORT && initState_q == INIT_READY
    |=> imr_q == $past(pin.data))
    else $error("mask write not taken");
endmodule

/* File: testbench/elic_source.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// request source standing at the request inputs
// ----------------------------------------------------------------
module elic_source
(
  input  wire logic       sys_clk,  // bench clock
  input  wire logic       resetn,   // reset, active low
  input  wire logic [7:0] reqSet,   // raise these lines
  input  wire logic       reqDrop,  // release all lines
  output logic      [7:0] reqLines  // request lines to device
);
  logic [7:0] heldLines_q;

  // lines rise from low and stay high until released
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      heldLines_q <= 8'h00;
    else if (reqDrop)
      heldLines_q <= 8'h00;
    else
      heldLines_q <= heldLines_q | reqSet;

  assign reqLines = heldLines_q;
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import elic_pkg::*;
;
  logic       sys_clk     = 1'b0;
  logic       resetn      = 1'b0;
  logic       csN         = 1'b1;
  logic       rdN         = 1'b1;
  logic       wrN         = 1'b1;
  logic       regSel      = 1'b0;
  logic [7:0] dataIn      = 8'h00;
  logic       irqAckN     = 1'b1;
  logic [7:0] reqSet      = 8'h00;
  logic       reqDrop     = 1'b0;
  logic       spIn        = 1'b1;
  logic [7:0] dataOut;
  logic       dataOe;
  logic [7:0] requestIn;
  logic       intOut;
  logic [2:0] casOut;
  logic       casOe;
  logic       spOut;
  logic       spOe;
  int         errCount    = 0;
  int         totalChecks = 0;

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  elic_core elic_core_i (
    .sys_clk(sys_clk), .resetn(resetn), .csN(csN), .rdN(rdN),
    .wrN(wrN), .regSel(regSel), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .irqAckN(irqAckN), .requestIn(requestIn),
    .intOut(intOut), .cascadeSelIn(3'h0), .cascadeSelOut(casOut),
    .cascadeSelOe(casOe), .slaveProgBufEnIn(spIn),
    .slaveProgBufEnOut(spOut), .slaveProgBufEnOe(spOe));

  elic_source elic_source_i (
    .sys_clk(sys_clk), .resetn(resetn), .reqSet(reqSet),
    .reqDrop(reqDrop), .reqLines(requestIn));

  // ----------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wrReg(input logic sel, input logic [7:0] d,
                       input logic cs = 1'b0);
    @(posedge sys_clk);
    csN    <= cs;
    regSel <= sel;
    dataIn <= d;
    wrN    <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wrN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    csN <= 1'b1;
  endtask

  task automatic rdReg(input logic sel, input logic cs,
                       input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    csN    <= cs;
    regSel <= sel;
    rdN    <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    check({what, " oe"}, 8'(dataOe), 8'(!cs));
    if (!cs)
      check(what, dataOut, exp);
    @(posedge sys_clk);
    rdN <= 1'b1;
    csN <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic ackPulse(input logic drive, input logic [7:0] exp,
                          input string what);
    @(posedge sys_clk);
    irqAckN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    check({what, " oe"}, 8'(dataOe), 8'(drive));
    check({what, " en"}, 8'(spOut), 8'(!drive));
    if (drive)
      check(what, dataOut, exp);
    @(posedge sys_clk);
    irqAckN <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic initWords(input logic [7:0] w1, w2, w3, w4);
    wrReg(OFS_COMMAND, w1);
    wrReg(OFS_DATA_PORT, w2);
    wrReg(OFS_DATA_PORT, w3);
    wrReg(OFS_DATA_PORT, w4);
  endtask

  task automatic source(input logic [7:0] set, input logic drop);
    @(posedge sys_clk);
    reqSet  <= set;
    reqDrop <= drop;
    @(posedge sys_clk);
    reqSet  <= 8'h00;
    reqDrop <= 1'b0;
  endtask

  task automatic waitInt(input logic exp);
    int n;
    n = 0;
    while (intOut !== exp && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("intOut", 8'(intOut), 8'(exp));
    if (n == 40)
      report_and_stop();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    check("reset oe", 8'(dataOe), 8'h00);
    check("reset int", 8'(intOut), 8'h00);
    initWords(8'hb5, 8'h12, 8'h00, 8'h00);
    #1 check("cas oe", 8'(casOe), 8'h01);
    check("buf oe", 8'(spOe), 8'h00);
    @(posedge sys_clk);
    spIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check("slave cas oe", 8'(casOe), 8'h00);
    @(posedge sys_clk);
    spIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check("master cas oe", 8'(casOe), 8'h01);
    wrReg(OFS_DATA_PORT, 8'hf0);
    rdReg(OFS_DATA_PORT, 1'b0, 8'hf0, "mask");
    wrReg(OFS_DATA_PORT, 8'h00);
    wrReg(OFS_DATA_PORT, 8'hff, 1'b1);
    rdReg(OFS_DATA_PORT, 1'b0, 8'h00, "mask cs");
    rdReg(OFS_DATA_PORT, 1'b1, 8'h00, "no cs");
    $display("test registers done");
    source(8'h08, 1'b0);
    waitInt(1'b1);
    wrReg(OFS_COMMAND, 8'h0a);
    rdReg(OFS_COMMAND, 1'b0, 8'h08, "requests");
    wrReg(OFS_DATA_PORT, 8'h08);
    waitInt(1'b0);
    wrReg(OFS_DATA_PORT, 8'h00);
    waitInt(1'b1);
    ackPulse(1'b1, CALL_OPCODE, "ack1");
    ackPulse(1'b1, 8'hac, "ack2");
    ackPulse(1'b1, 8'h12, "ack3");
    source(8'h00, 1'b1);
    wrReg(OFS_COMMAND, 8'h0b);
    rdReg(OFS_COMMAND, 1'b0, 8'h08, "service");
    wrReg(OFS_COMMAND, 8'h20);
    rdReg(OFS_COMMAND, 1'b0, 8'h00, "done");
    $display("test host8 done");
    source(8'h02, 1'b0);
    waitInt(1'b1);
    source(8'h00, 1'b1);
    ackPulse(1'b1, CALL_OPCODE, "drop1");
    ackPulse(1'b1, 8'hbc, "drop2");
    ackPulse(1'b1, 8'h12, "drop3");
    rdReg(OFS_COMMAND, 1'b0, 8'h00, "drop svc");
    $display("test dropped request done");
    initWords(8'hbd, 8'h48, 8'h00, 8'h0f);
    #1 check("buf oe", 8'(spOe), 8'h01);
    source(8'h20, 1'b0);
    waitInt(1'b1);
    ackPulse(1'b0, 8'h00, "ack16a");
    ackPulse(1'b1, 8'h4d, "ack16b");
    source(8'h00, 1'b1);
    wrReg(OFS_COMMAND, 8'h0b);
    rdReg(OFS_COMMAND, 1'b0, 8'h00, "auto");
    source(8'h04, 1'b0);
    waitInt(1'b1);
    wrReg(OFS_COMMAND, 8'h0c);
    rdReg(OFS_COMMAND, 1'b0, 8'h82, "poll");
    rdReg(OFS_COMMAND, 1'b0, 8'h04, "poll svc");
    wrReg(OFS_COMMAND, 8'h62);
    rdReg(OFS_COMMAND, 1'b0, 8'h00, "specific");
    source(8'h00, 1'b1);
    $display("test host16 buffered done");
    report_and_stop();
  end
endmodule
